/* File: core/nio_port.sv */
// Four-nibble bidirectional I/O port with APB registers and low-level interrupts
`timescale 1ns/1ps
`default_nettype none
`include "nio_defines.svh"

module nio_port
	import nio_pkg::*;
#(
	parameter bit SINGLE_SUPPLY    = 1'b0,
	parameter bit PD_HI_INPUT_ONLY = 1'b0
) (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Alternate functions
	input  wire logic        ALARM_I,
	input  wire logic [7:0]  SEG_I,
	// Pads
	input  wire logic [15:0] PIO_I,
	output logic      [15:0] PIO_O,
	output logic      [15:0] PIO_OE_N_O,
	output logic      [15:0] PIO_PU_O,
	// Interrupt
	output logic             IRQ_O
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	nio_port_t   port_reg;
	logic [3:0]  misc_reg;
	logic [3:0]  puseg_reg;
	logic [3:0]  mask_reg;
	logic [3:0]  stat_reg;
	logic [15:0] lvl;
	nio_pad_t    pad_next;
	logic        setup;
	logic        wr_acc;
	logic [31:0] rdata_next;
	logic        map_ok;
	logic        pc_seg;
	logic        pd_seg;
	logic [15:0] seg_pin;
	logic        port_evt;
	logic        ext_evt;
	logic [3:0]  evt;

	// Index match on an aligned word address
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
	endfunction

	// Nibble selection from a 16-bit vector
	function automatic logic [3:0] nib(input logic [15:0] v, input int n);
		nib = v[4*n +: 4];
	endfunction

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	nio_sync u_sync (
		.clk_i  (CLK_I),
		.srst_i (SRST_I),
		.pin_i  (PIO_I),
		.lvl_o  (lvl)
	);

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign setup  = PSEL_I && !PENABLE_I;
	assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

	always_comb begin
		rdata_next = 32'h0000_0000;
		map_ok     = 1'b1;
		if (hit(PADDR_I, `NIO_IDX_PA_DATA)) begin
			rdata_next[3:0] = nib(port_reg.data, 0);
		end else if (hit(PADDR_I, `NIO_IDX_PB_DATA)) begin
			rdata_next[3:0] = nib(port_reg.data, 1);
		end else if (hit(PADDR_I, `NIO_IDX_PC_DATA)) begin
			rdata_next[3:0] = nib(port_reg.data, 2);
		end else if (hit(PADDR_I, `NIO_IDX_PD_DATA)) begin
			rdata_next[3:0] = nib(port_reg.data, 3);
		end else if (hit(PADDR_I, `NIO_IDX_PA_DIR)) begin
			rdata_next[3:0] = nib(port_reg.dir, 0);
		end else if (hit(PADDR_I, `NIO_IDX_PB_DIR)) begin
			rdata_next[3:0] = nib(port_reg.dir, 1);
		end else if (hit(PADDR_I, `NIO_IDX_PC_DIR)) begin
			rdata_next[3:0] = nib(port_reg.dir, 2);
		end else if (hit(PADDR_I, `NIO_IDX_PD_DIR)) begin
			rdata_next[3:0] = nib(port_reg.dir, 3);
		end else if (hit(PADDR_I, `NIO_IDX_MISC_CTRL)) begin
			rdata_next[3:0] = misc_reg;
		end else if (hit(PADDR_I, `NIO_IDX_PU_SEG)) begin
			rdata_next[3:0] = puseg_reg;
		end else if (hit(PADDR_I, `NIO_IDX_IRQ_MASK)) begin
			rdata_next[3:0] = mask_reg;
		end else if (hit(PADDR_I, `NIO_IDX_IRQ_STAT)) begin
			rdata_next[3:0] = stat_reg;
		end else if (hit(PADDR_I, `NIO_IDX_PIN_LEVEL)) begin
			rdata_next[15:0] = lvl;
		end else begin
			map_ok = 1'b0;
		end
	end

	// Answer prepared in setup, seen at the first access edge
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end else if (setup) begin
			PREADY_O  <= 1'b1;
			PSLVERR_O <= !map_ok;
			PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rdata_next;
		end else begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end

	// ****************************************************************
	// Port data and direction
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			port_reg.data <= `NIO_RST_PINS;
			port_reg.dir  <= `NIO_RST_PINS;
		end else if (wr_acc) begin
			for (int n = 0; n < 4; n++) begin
				if (hit(PADDR_I, `NIO_IDX_PA_DATA + 10'(n))) begin
					port_reg.data[4*n +: 4] <= PWDATA_I[3:0];
				end
				if (hit(PADDR_I, `NIO_IDX_PA_DIR + 10'(n))) begin
					port_reg.dir[4*n +: 4] <= PWDATA_I[3:0];
				end
			end
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			misc_reg  <= `NIO_RST_MISC;
			puseg_reg <= `NIO_RST_NIBBLE;
			mask_reg  <= `NIO_RST_NIBBLE;
		end else if (wr_acc) begin
			if (hit(PADDR_I, `NIO_IDX_MISC_CTRL)) begin
				misc_reg <= {1'b0, PWDATA_I[2:0]};
			end
			if (hit(PADDR_I, `NIO_IDX_PU_SEG)) begin
				puseg_reg <= {PWDATA_I[3:1], 1'b0};
			end
			if (hit(PADDR_I, `NIO_IDX_IRQ_MASK)) begin
				mask_reg <= PWDATA_I[3:0] & 4'h9;
			end
		end
	end

	// ****************************************************************
	// Pad drive
	// ****************************************************************
	assign pc_seg = puseg_reg[`NIO_BIT_PC_SEG];
	assign pd_seg = puseg_reg[`NIO_BIT_PD_SEG];

	always_comb begin
		seg_pin = 16'h0000;
		if (pc_seg) begin
			seg_pin[11:8] = 4'hf;
		end
		if (pd_seg) begin
			seg_pin[15:12] = PD_HI_INPUT_ONLY ? 4'h3 : 4'hf;
		end
	end

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pad_next.lvl[i]  = port_reg.data[i];
			pad_next.oe_n[i] = !port_reg.dir[i];
			pad_next.pu[i]   = puseg_reg[`NIO_BIT_GPULLUP] && port_reg.data[i] && !port_reg.dir[i];
			if (seg_pin[i]) begin
				pad_next.lvl[i]  = SEG_I[i[2:0]];
				pad_next.oe_n[i] = 1'b0;
				pad_next.pu[i]   = 1'b0;
			end
		end
		if (PD_HI_INPUT_ONLY) begin
			pad_next.oe_n[15:14] = 2'b11;
		end
		if (misc_reg[`NIO_BIT_ALARM_SEL]) begin
			pad_next.lvl[2:1]  = {2{ALARM_I}};
			pad_next.oe_n[2:1] = 2'b00;
			pad_next.pu[2:1]   = 2'b00;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			PIO_O      <= `NIO_RST_PINS;
			PIO_OE_N_O <= `NIO_RST_OE_N;
			PIO_PU_O   <= `NIO_RST_PINS;
		end else begin
			PIO_O      <= pad_next.lvl;
			PIO_OE_N_O <= pad_next.oe_n;
			PIO_PU_O   <= pad_next.pu;
		end
	end

	// ****************************************************************
	// Interrupt requests
	// ****************************************************************
	assign port_evt = |(~lvl[7:4] & ~port_reg.dir[7:4])
		| (!pc_seg && |(~lvl[11:8] & ~port_reg.dir[11:8]));
	assign ext_evt = !lvl[0] && (!SINGLE_SUPPLY || (!port_reg.dir[0] && port_reg.data[0]));
	assign evt = {ext_evt, 2'b00, port_evt};

	// Sticky flags, write one clears, a new event wins over the clear
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			stat_reg <= `NIO_RST_NIBBLE;
		end else if (wr_acc && hit(PADDR_I, `NIO_IDX_IRQ_STAT)) begin
			stat_reg <= (stat_reg & ~PWDATA_I[3:0]) | evt;
		end else begin
			stat_reg <= stat_reg | evt;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(stat_reg & mask_reg);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);

	property p_dir_reset;
		disable iff (1'b0) SRST_I |=> (port_reg.dir == 16'h0000) && (PIO_OE_N_O == 16'hffff);
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction not input after reset");

	property p_data_write;
		(wr_acc && hit(PADDR_I, `NIO_IDX_PB_DATA)) |=> (port_reg.data[7:4] == $past(PWDATA_I[3:0]));
	endproperty
	a_data_write: assert property (p_data_write) else $error("port data write lost");

	property p_pullup;
		(puseg_reg[`NIO_BIT_GPULLUP] == 1'b0) ##1 1'b1 |-> PIO_PU_O == 16'h0000;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up active with global enable off");

	property p_pu_data;
		!port_reg.data[5] |=> !PIO_PU_O[5];
	endproperty
	a_pu_data: assert property (p_pu_data) else $error("pull-up on with data bit zero");

	property p_pu_out;
		port_reg.dir[6] |=> !PIO_PU_O[6];
	endproperty
	a_pu_out: assert property (p_pu_out) else $error("pull-up on an output pin");

	property p_alarm;
		misc_reg[`NIO_BIT_ALARM_SEL] |=> (PIO_O[1] == $past(ALARM_I)) && (PIO_OE_N_O[2:1] == 2'b00);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not on port A pins");

	property p_seg;
		(pc_seg && $stable(pc_seg)) |=> (PIO_O[11:8] == $past(SEG_I[3:0])) && (PIO_OE_N_O[11:8] == 4'h0);
	endproperty
	a_seg: assert property (p_seg) else $error("port C not carrying segments");

	property p_pd_in;
		PD_HI_INPUT_ONLY |-> ##1 PIO_OE_N_O[15:14] == 2'b11;
	endproperty
	a_pd_in: assert property (p_pd_in) else $error("input-only pins driven");

	property p_port_irq;
		(pc_seg && lvl[7:4] == 4'hf && !stat_reg[`NIO_BIT_IRQ_PORT]) |=> !stat_reg[`NIO_BIT_IRQ_PORT];
	endproperty
	a_port_irq: assert property (p_port_irq) else $error("port C raised interrupt in segment mode");

	property p_port_set;
		(!lvl[4] && !port_reg.dir[4]) ##1 (!lvl[4] && !port_reg.dir[4])
			|-> stat_reg[`NIO_BIT_IRQ_PORT] ##1 stat_reg[`NIO_BIT_IRQ_PORT];
	endproperty
	a_port_set: assert property (p_port_set) else $error("port flag not held while pin low");

	property p_ext_set;
		(!lvl[0] && !SINGLE_SUPPLY) |=> stat_reg[`NIO_BIT_IRQ_EXT];
	endproperty
	a_ext_set: assert property (p_ext_set) else $error("external flag not set on low");

	property p_irq_out;
		|(stat_reg & mask_reg) |=> IRQ_O;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt output missing");

	c_port_irq: cover property (!lvl[8] && !pc_seg ##1 stat_reg[0]);
	c_ext_irq: cover property (stat_reg[3] && mask_reg[3] ##1 IRQ_O);
	c_alarm: cover property (misc_reg[0] ##1 PIO_OE_N_O[1] == 1'b0);
	c_clear: cover property (wr_acc && hit(PADDR_I, `NIO_IDX_IRQ_STAT) ##1 stat_reg == 4'h0);

endmodule
`default_nettype wire

/* File: core/nio_defines.svh */
// Register indices, field positions, reset values and sync depth of the nibble I/O port
`ifndef NIO_DEFINES_SVH
`define NIO_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define NIO_IDX_IRQ_MASK   10'h000
`define NIO_IDX_IRQ_STAT   10'h001
`define NIO_IDX_PA_DATA    10'h008
`define NIO_IDX_PB_DATA    10'h009
`define NIO_IDX_PC_DATA    10'h00a
`define NIO_IDX_PD_DATA    10'h00b
`define NIO_IDX_MISC_CTRL  10'h013
`define NIO_IDX_PU_SEG     10'h015
`define NIO_IDX_PIN_LEVEL  10'h016
`define NIO_IDX_PA_DIR     10'h01b
`define NIO_IDX_PB_DIR     10'h01c
`define NIO_IDX_PC_DIR     10'h01d
`define NIO_IDX_PD_DIR     10'h01e

// ****************************************************************
// Field positions
// ****************************************************************
`define NIO_BIT_ALARM_SEL  0
`define NIO_BIT_HEAVY_LOAD 1
`define NIO_BIT_LCD_OFF    2
`define NIO_BIT_PC_SEG     1
`define NIO_BIT_PD_SEG     2
`define NIO_BIT_GPULLUP    3
`define NIO_BIT_IRQ_PORT   0
`define NIO_BIT_IRQ_EXT    3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define NIO_RST_NIBBLE     4'h0
`define NIO_RST_MISC       4'h4
`define NIO_RST_PINS       16'h0000
`define NIO_RST_OE_N       16'hffff
`define NIO_SYNC_STAGES    3

`endif

/* File: core/nio_pkg.sv */
// Types shared by the nibble I/O port files
package nio_pkg;

	// Pad-facing bundle: level, enable (low drives) and pull-up
	typedef struct packed {
		logic [15:0] lvl;
		logic [15:0] oe_n;
		logic [15:0] pu;
	} nio_pad_t;

	// Stored port state: data and direction, four nibbles each
	typedef struct packed {
		logic [15:0] data;
		logic [15:0] dir;
	} nio_port_t;

endpackage

/* File: core/nio_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "nio_defines.svh"

module nio_sync
	import nio_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Raw pins and filtered levels
	input  wire logic [15:0] pin_i,
	output logic      [15:0] lvl_o
);

	logic [15:0] s1_reg;
	logic [15:0] s2_reg;
	logic [15:0] s3_reg;

	// Stage chain
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_reg <= `NIO_RST_OE_N;
			s2_reg <= `NIO_RST_OE_N;
			s3_reg <= `NIO_RST_OE_N;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lvl_o <= `NIO_RST_OE_N;
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					lvl_o[i] <= s3_reg[i];
				end
			end
		end
	end

endmodule
`default_nettype wire

/* File: verification/nio_pad_model.sv */
// Pad-side model: board drivers, pull-ups and floating pins
`timescale 1ns/1ps
`default_nettype none

module nio_pad_model
	import nio_pkg::*;
(
	// Clock
	input  wire logic        clk_i,
	// Pad bundle from the port
	input  wire nio_pad_t    pad_i,
	// Board drivers
	input  wire logic [15:0] ext_en_i,
	input  wire logic [15:0] ext_lvl_i,
	// Resolved pin levels
	output logic      [15:0] pin_o
);
	// ****************************************************************
	// Floating pins toggle every cycle
	// ****************************************************************
	logic [15:0] float_q = 16'h0000;

	always_ff @(posedge clk_i) begin
		float_q <= ~float_q;
	end

	// ****************************************************************
	// Pin resolution
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (!pad_i.oe_n[i]) begin
				pin_o[i] = pad_i.lvl[i];
			end else if (ext_en_i[i]) begin
				pin_o[i] = ext_lvl_i[i];
			end else if (pad_i.pu[i]) begin
				pin_o[i] = 1'b1;
			end else begin
				pin_o[i] = float_q[i];
			end
		end
	end
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the nibble I/O port
`timescale 1ns/1ps
`default_nettype none
`include "nio_defines.svh"

module tb_top
	import nio_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        alarm;
	logic [7:0]  seg;
	logic [15:0] pin;
	logic [15:0] pio_o;
	logic [15:0] oe_n;
	logic [15:0] pu;
	logic        irq;
	logic [15:0] pin_opt;
	logic [15:0] pio_opt;
	logic [15:0] oe_n_opt;
	logic [15:0] pu_opt;
	logic        irq_opt;
	nio_pad_t    pad_bus;
	nio_pad_t    pad_bus_opt;
	logic [15:0] ext_en;
	logic [15:0] ext_lvl;
	logic [31:0] rdat;
	logic        rerr;
	int          n_fail;
	int          check_count;
	int          cyc;

	nio_port dut (
		.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .ALARM_I(alarm), .SEG_I(seg), .PIO_I(pin), .PIO_O(pio_o),
		.PIO_OE_N_O(oe_n), .PIO_PU_O(pu), .IRQ_O(irq)
	);

	assign pad_bus = {pio_o, oe_n, pu};

	nio_pad_model pads (
		.clk_i(clk), .pad_i(pad_bus), .ext_en_i(ext_en),
		.ext_lvl_i(ext_lvl), .pin_o(pin)
	);

	// Second port with both code options set
	nio_port #(.SINGLE_SUPPLY(1'b1), .PD_HI_INPUT_ONLY(1'b1)) dut_opt (
		.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(), .PREADY_O(),
		.PSLVERR_O(), .ALARM_I(alarm), .SEG_I(seg), .PIO_I(pin_opt), .PIO_O(pio_opt),
		.PIO_OE_N_O(oe_n_opt), .PIO_PU_O(pu_opt), .IRQ_O(irq_opt)
	);

	assign pad_bus_opt = {pio_opt, oe_n_opt, pu_opt};

	nio_pad_model pads_opt (
		.clk_i(clk), .pad_i(pad_bus_opt), .ext_en_i(ext_en),
		.ext_lvl_i(ext_lvl), .pin_o(pin_opt)
	);

	// ****************************************************************
	// Clock and timeout
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic print_verdict();
		if (n_fail == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] ix, input logic [3:0] d);
		apb(1'b1, {ix, 2'b00}, {28'h000_0000, d});
	endtask

	task automatic rd(input string nm, input logic [9:0] ix, input logic [31:0] exp);
		apb(1'b0, {ix, 2'b00}, 32'h0000_0000);
		chk(nm, rdat, exp);
	endtask

	task automatic wait_irq(input logic exp);
		int n;
		n = 0;
		while (irq !== exp && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, exp});
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
		pwdata = 32'h0000_0000; alarm = 1'b0; seg = 8'h00; ext_en = 16'hffff; ext_lvl = 16'hffff;
		n_fail = 0; check_count = 0; cyc = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		// Reset state
		chk("oe_n rst", {16'h0000, oe_n}, 32'h0000_ffff);
		chk("pu rst", {16'h0000, pu}, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			rd("dir rst", `NIO_IDX_PA_DIR + 10'(i), 32'h0000_0000);
			rd("data rst", `NIO_IDX_PA_DATA + 10'(i), 32'h0000_0000);
		end
		rd("misc rst", `NIO_IDX_MISC_CTRL, 32'h0000_0004);
		rd("stat rst", `NIO_IDX_IRQ_STAT, 32'h0000_0000);
		chk("err ok", {31'h0000_0000, rerr}, 32'h0000_0000);
		// Data and direction registers drive the pads
		wr(`NIO_IDX_PA_DATA, 4'ha); wr(`NIO_IDX_PB_DATA, 4'h5);
		wr(`NIO_IDX_PC_DATA, 4'hc); wr(`NIO_IDX_PD_DATA, 4'h3);
		for (int i = 0; i < 4; i++) begin
			wr(`NIO_IDX_PA_DIR + 10'(i), 4'hf);
			rd("dir", `NIO_IDX_PA_DIR + 10'(i), 32'h0000_000f);
		end
		rd("pc data", `NIO_IDX_PC_DATA, 32'h0000_000c);
		chk("oe_n out", {16'h0000, oe_n}, 32'h0000_0000);
		chk("pio out", {16'h0000, pio_o}, 32'h0000_3c5a);
		for (int i = 0; i < 4; i++) wr(`NIO_IDX_PA_DIR + 10'(i), 4'h0);
		@(posedge clk);
		@(posedge clk);
		chk("oe_n in", {16'h0000, oe_n}, 32'h0000_ffff);
		// Pull-ups: global, per data bit, input only
		ext_en <= 16'hff0f;
		wr(`NIO_IDX_PU_SEG, 4'h8);
		@(posedge clk); @(posedge clk);
		chk("pu on", {16'h0000, pu}, 32'h0000_3c5a);
		repeat (8) @(posedge clk);
		rd("pin lvl", `NIO_IDX_PIN_LEVEL, 32'h0000_ffff);
		chk("pull high", {28'h000_0000, rdat[7:4] & 4'h5}, 32'h0000_0005);
		wr(`NIO_IDX_PB_DIR, 4'h1);
		@(posedge clk); @(posedge clk);
		chk("pu out", {16'h0000, pu}, 32'h0000_3c4a);
		chk("pb0 out", {31'h0000_0000, oe_n[4] | ~pio_o[4]}, 32'h0000_0000);
		wr(`NIO_IDX_PU_SEG, 4'h0);
		@(posedge clk); @(posedge clk);
		chk("pu off", {16'h0000, pu}, 32'h0000_0000);
		wr(`NIO_IDX_PB_DIR, 4'h0);
		ext_en <= 16'hffff;
		// Alarm on PA1, PA2
		wr(`NIO_IDX_PA_DATA, 4'h0);
		wr(`NIO_IDX_MISC_CTRL, 4'h1);
		alarm <= 1'b1;
		repeat (3) @(posedge clk);
		chk("alarm hi", {28'h000_0000, oe_n[2:1], pio_o[2:1]}, 32'h0000_0003);
		alarm <= 1'b0;
		repeat (3) @(posedge clk);
		chk("alarm lo", {28'h000_0000, oe_n[2:1], pio_o[2:1]}, 32'h0000_0000);
		wr(`NIO_IDX_MISC_CTRL, 4'h0);
		@(posedge clk);
		@(posedge clk);
		chk("alarm off", {30'h0000_0000, oe_n[2:1]}, 32'h0000_0003);
		// Segments on C and D; data writes do not reach them
		rd("stat pre", `NIO_IDX_IRQ_STAT, 32'h0000_0009);
		wr(`NIO_IDX_IRQ_STAT, 4'hf);
		seg <= 8'ha4;
		wr(`NIO_IDX_PU_SEG, 4'h6);
		wr(`NIO_IDX_PC_DATA, 4'hf);
		repeat (3) @(posedge clk);
		chk("seg out", {16'h0000, oe_n[15:8], pio_o[15:8]}, 32'h0000_00a4);
		chk("seg opt", {16'h0000, oe_n_opt[15:8], pio_opt[15:8]}, 32'h0000_c024);
		repeat (8) @(posedge clk);
		rd("seg no irq", `NIO_IDX_IRQ_STAT, 32'h0000_0000);
		wr(`NIO_IDX_PU_SEG, 4'h0);
		repeat (8) @(posedge clk);
		// Port interrupt from PB0, flag held while low
		wr(`NIO_IDX_IRQ_STAT, 4'hf);
		wr(`NIO_IDX_IRQ_MASK, 4'h1);
		ext_lvl <= 16'hffef;
		wait_irq(1'b1);
		wr(`NIO_IDX_IRQ_STAT, 4'h1);
		rd("stat held", `NIO_IDX_IRQ_STAT, 32'h0000_0001);
		ext_lvl <= 16'hffff;
		repeat (8) @(posedge clk);
		wr(`NIO_IDX_IRQ_STAT, 4'h1);
		rd("stat clr", `NIO_IDX_IRQ_STAT, 32'h0000_0000);
		wait_irq(1'b0);
		// Masked port interrupt from PC1
		wr(`NIO_IDX_IRQ_MASK, 4'h0);
		ext_lvl <= 16'hfdff;
		repeat (10) @(posedge clk);
		rd("stat pc", `NIO_IDX_IRQ_STAT, 32'h0000_0001);
		chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
		ext_lvl <= 16'hffff;
		repeat (8) @(posedge clk);
		wr(`NIO_IDX_IRQ_STAT, 4'h1);
		// External interrupt on PA0
		wr(`NIO_IDX_IRQ_MASK, 4'h8);
		ext_lvl <= 16'hfffe;
		wait_irq(1'b1);
		rd("stat ext", `NIO_IDX_IRQ_STAT, 32'h0000_0008);
		chk("ext gated", {31'h0000_0000, irq_opt}, 32'h0000_0000);
		wr(`NIO_IDX_PA_DATA, 4'h1);
		repeat (3) @(posedge clk);
		chk("ext ready", {31'h0000_0000, irq_opt}, 32'h0000_0001);
		ext_lvl <= 16'hffff;
		repeat (8) @(posedge clk);
		wr(`NIO_IDX_IRQ_STAT, 4'h8);
		wait_irq(1'b0);
		// Unmapped and misaligned accesses
		rd("unmapped", 10'h00c, 32'h0000_0000);
		chk("err unmapped", {31'h0000_0000, rerr}, 32'h0000_0001);
		apb(1'b1, 12'h021, 32'h0000_000f);
		chk("err misalign", {31'h0000_0000, rerr}, 32'h0000_0001);
		rd("pa kept", `NIO_IDX_PA_DATA, 32'h0000_0001);
		print_verdict();
	end
endmodule

`default_nettype wire
